// ### core/option_regs.sv
// Function
// [RQ1] each option register takes one write after reset, then holds it
// [RQ2] later writes before the next reset are ignored
// [RQ3] any reset clears option bits except the voltage-mode bit
// [RQ4] registers sit at indices 0x1E and 0x1F
// [RQ5] reads always return the latched contents
// [RQ6] voltage-mode bit written once per power-on reset, cleared only there
// [RQ7] oscillator runs in stop when osc-run bit set, else stopped
// [RQ8] serial clock is bus clock when 1, crystal clock when 0
// [RQ9] watchdog timeout 8176 cycles when rate bit 1, else 262128
// [RQ10] monitor active in stop only if stop enable 1 and power-disable 0
// [RQ11] reset-disable bit blocks monitor resets
// [RQ12] power-disable bit powers the monitor down
// [RQ13] voltage-mode bit picks 5-V mode when 1, 3-V when 0
// [RQ14] stop exit waits 32 cycles with short recovery, else 4096
// [RQ15] stop exit by external reset always uses the long delay
// [RQ16] stop instruction runs only when stop enable is set
// [RQ17] a disabled stop instruction gives an illegal-opcode reset
// [RQ18] watchdog-disable bit disables the watchdog
// [RQ19] software keeps short recovery clear with an external crystal
// [RQ20] software writes the options right after reset
`timescale 1ns/100ps
`include "option_regs_params.svh"

module option_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic stop_instr_in,
  input wire logic lowvolt_trip_in,
  input wire logic ext_reset_exit_in,
  output logic avs_waitrequest_out,
  output logic [31:0] avs_readdata_out,
  output logic illegal_opcode_reset_out,
  output logic lowvolt_reset_out,
  output logic stop_accept_out,
  output logic [12:0] stop_recovery_out,
  output option_regs_pkg::option_out_t opts_out
);

  // ***************************************************************
  // state
  // ***************************************************************
  option_regs_pkg::state_t s_q;
  option_regs_pkg::state_t s_d;
  logic mode_q;
  logic mode_used_q;
  logic mode_d;
  logic mode_used_d;

  wire logic req = (avs_read_in | avs_write_in) & s_q.waitreq;
  wire logic wr = avs_write_in & s_q.waitreq & avs_byteenable_in[0];

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    mode_d = mode_q;
    mode_used_d = mode_used_q;
    // one wait cycle: request seen with waitrequest high, answer next edge
    s_d.waitreq = 1'b1;
    if (req) begin
      s_d.waitreq = 1'b0;
    end
    if (wr && avs_address_in == `OPT_REG_TWO_ADDR && !s_q.two_used) begin
      s_d.reg_two = avs_writedata_in[7:0] & `OPT2_IMPL_MASK; // [RQ1] [RQ4]
      s_d.two_used = 1'b1; // [RQ2]
    end
    if (wr && avs_address_in == `OPT_REG_ONE_ADDR) begin
      if (!s_q.one_used) begin
        s_d.reg_one = avs_writedata_in[7:0]; // [RQ1] [RQ4]
        s_d.one_used = 1'b1; // [RQ2]
      end
      if (!mode_used_q) begin
        mode_d = avs_writedata_in[`OPT1_LV_MODE_BIT]; // [RQ6]
        mode_used_d = 1'b1;
      end
    end
    s_d.rdata = 32'h0000_0000;
    if (req && avs_read_in) begin
      unique case (avs_address_in)
        `OPT_REG_TWO_ADDR: s_d.rdata = {24'h000000, s_q.reg_two}; // [RQ5]
        `OPT_REG_ONE_ADDR: begin
          s_d.rdata = {24'h000000, s_q.reg_one}; // [RQ5]
          s_d.rdata[`OPT1_LV_MODE_BIT] = mode_q;
        end
        `OPT_STAT_ADDR: s_d.rdata = {28'h0000000, mode_used_q,
                                     s_q.one_used, s_q.two_used, 1'b0};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // decoded option outputs
    s_d.opts.osc_run_in_stop = s_q.reg_two[`OPT2_OSC_RUN_BIT]; // [RQ7]
    s_d.opts.serial_clock_source_sel =
      s_q.reg_two[`OPT2_SERIAL_SRC_BIT]; // [RQ8]
    s_d.opts.watchdog_timeout = s_q.reg_one[`OPT1_WD_RATE_BIT] ?
      `WD_SHORT_CYCLES : `WD_LONG_CYCLES; // [RQ9]
    s_d.opts.watchdog_disable = s_q.reg_one[`OPT1_WD_DIS_BIT]; // [RQ18]
    s_d.opts.lowvolt_power_disable = s_q.reg_one[`OPT1_LV_PWRD_BIT]; // [RQ12]
    s_d.opts.lowvolt_reset_disable = s_q.reg_one[`OPT1_LV_RSTD_BIT]; // [RQ11]
    s_d.opts.lowvolt_in_stop_en = s_q.reg_one[`OPT1_LV_STOP_BIT] &
      ~s_q.reg_one[`OPT1_LV_PWRD_BIT]; // [RQ10]
    s_d.opts.lowvolt_voltage_mode = mode_q; // [RQ13]
    s_d.opts.stop_recovery_cycles = s_q.reg_one[`OPT1_SHORT_REC_BIT] ?
      `REC_SHORT_CYCLES : `REC_LONG_CYCLES; // [RQ14]
    s_d.opts.stop_instr_enable = s_q.reg_one[`OPT1_STOP_EN_BIT]; // [RQ16]
    // stop instruction handling
    s_d.stop_go = stop_instr_in & s_q.reg_one[`OPT1_STOP_EN_BIT]; // [RQ16]
    s_d.illegal_stop = stop_instr_in &
      ~s_q.reg_one[`OPT1_STOP_EN_BIT]; // [RQ17]
    s_d.recovery = ext_reset_exit_in ? `REC_LONG_CYCLES :
      s_d.opts.stop_recovery_cycles; // [RQ15]
    s_d.lv_reset = lowvolt_trip_in & ~s_q.reg_one[`OPT1_LV_RSTD_BIT] &
      ~s_q.reg_one[`OPT1_LV_PWRD_BIT]; // [RQ11]
    s_d.mode_bit = mode_q;
    s_d.mode_used = mode_used_q;
  end

  // ***************************************************************
  // registers: general reset clears the option bytes, sets waitrequest and the long counts; voltage mode is kept
  // ***************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0; // [RQ3]
      s_q.waitreq <= 1'b1;
      s_q.opts.watchdog_timeout <= `WD_LONG_CYCLES;
      s_q.opts.stop_recovery_cycles <= `REC_LONG_CYCLES;
      s_q.recovery <= `REC_LONG_CYCLES;
    end else begin
      s_q <= s_d;
    end
  end

  // voltage mode lives on power-on reset only, so a warm reset keeps it
  always_ff @(posedge clk_in or negedge por_n_in) begin
    if (!por_n_in) begin
      mode_q <= 1'b0; // [RQ6]
      mode_used_q <= 1'b0;
    end else if (rst_n_in) begin
      mode_q <= mode_d;
      mode_used_q <= mode_used_d;
    end
  end

  assign avs_waitrequest_out = s_q.waitreq;
  assign avs_readdata_out = s_q.rdata;
  assign illegal_opcode_reset_out = s_q.illegal_stop;
  assign lowvolt_reset_out = s_q.lv_reset;
  assign stop_accept_out = s_q.stop_go;
  assign stop_recovery_out = s_q.recovery;
  assign opts_out = s_q.opts;

endmodule

// ### inc/option_regs_params.svh
`ifndef OPTION_REGS_PARAMS_SVH
`define OPTION_REGS_PARAMS_SVH

// ***************************************************************
// register byte addresses (word index = byte address / 4)
// ***************************************************************
`define OPT_REG_TWO_IDX 16'h001E
`define OPT_REG_ONE_IDX 16'h001F
`define OPT_REG_TWO_ADDR 18'h00078
`define OPT_REG_ONE_ADDR 18'h0007C
`define OPT_CTRL_ADDR 18'h00080
`define OPT_STAT_ADDR 18'h00084

// ***************************************************************
// option register two field positions
// ***************************************************************
`define OPT2_OSC_RUN_BIT 1
`define OPT2_SERIAL_SRC_BIT 0

// ***************************************************************
// option register one field positions
// ***************************************************************
`define OPT1_WD_RATE_BIT 7
`define OPT1_LV_STOP_BIT 6
`define OPT1_LV_RSTD_BIT 5
`define OPT1_LV_PWRD_BIT 4
`define OPT1_LV_MODE_BIT 3
`define OPT1_SHORT_REC_BIT 2
`define OPT1_STOP_EN_BIT 1
`define OPT1_WD_DIS_BIT 0

// ***************************************************************
// reset values and timing counts
// ***************************************************************
`define OPT_RESET_VALUE 8'h00
`define OPT2_IMPL_MASK 8'h03
`define WD_SHORT_CYCLES 19'h01FF0
`define WD_LONG_CYCLES 19'h3FFF0
`define REC_SHORT_CYCLES 13'h0020
`define REC_LONG_CYCLES 13'h1000

`endif

// ### inc/option_regs_pkg.sv
package option_regs_pkg;

  typedef struct packed {
    logic osc_run_in_stop;
    logic serial_clock_source_sel;
    logic [18:0] watchdog_timeout;
    logic watchdog_disable;
    logic lowvolt_power_disable;
    logic lowvolt_reset_disable;
    logic lowvolt_in_stop_en;
    logic lowvolt_voltage_mode;
    logic [12:0] stop_recovery_cycles;
    logic stop_instr_enable;
  } option_out_t;

  typedef struct packed {
    logic [7:0] reg_two;
    logic [7:0] reg_one;
    logic two_used;
    logic one_used;
    logic mode_used;
    logic mode_bit;
    logic waitreq;
    logic [31:0] rdata;
    logic illegal_stop;
    logic lv_reset;
    logic stop_go;
    logic [12:0] recovery;
    option_out_t opts;
  } state_t;

endpackage

// ### verification/option_regs_props.sv
`timescale 1ns/100ps
module option_regs_props (
  input logic clk_in,
  input logic rst_n_in,
  input logic avs_read_in,
  input logic avs_write_in,
  input logic avs_waitrequest_out,
  input logic [31:0] avs_readdata_out,
  input logic stop_instr_in,
  input logic stop_accept_out,
  input logic illegal_opcode_reset_out,
  input logic lowvolt_trip_in,
  input logic lowvolt_reset_out,
  input logic ext_reset_exit_in,
  input logic [12:0] stop_recovery_out,
  input option_regs_pkg::option_out_t opts_out
);
  // ******************************
  // bus and option checks
  // ******************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_ack_next: assert property ((avs_read_in || avs_write_in)
    && avs_waitrequest_out |=> !avs_waitrequest_out) else $error("late ack");
  a_ack_single: assert property (!avs_waitrequest_out
    |=> avs_waitrequest_out) else $error("ack held");
  a_idle_rdata: assert property (avs_waitrequest_out
    |-> avs_readdata_out == 32'h0) else $error("idle data");
  a_stop_split: assert property (stop_instr_in
    |=> stop_accept_out != illegal_opcode_reset_out) else $error("stop");
  a_stop_quiet: assert property (!stop_instr_in |=> !stop_accept_out
    && !illegal_opcode_reset_out) else $error("stray stop");
  a_lv_cause: assert property (lowvolt_reset_out
    |-> $past(lowvolt_trip_in)) else $error("lv reset");
  a_rec_long: assert property (ext_reset_exit_in
    |=> stop_recovery_out == 13'h1000) else $error("recovery");
  a_wd_values: assert property (opts_out.watchdog_timeout
    inside {19'h01FF0, 19'h3FFF0}) else $error("timeout");
  // first edges after release are skipped: the kept mode bit may settle
  a_opts_hold: assert property ($past(rst_n_in, 4) &&
    !$past(avs_write_in) && !$past(avs_write_in, 2) &&
    !$past(avs_write_in, 3) |-> $stable(opts_out)) else $error("opts");
endmodule
bind option_regs option_regs_props i_option_regs_props (.*);

// ### verification/option_regs_tb.sv
`timescale 1ns/100ps
`include "option_regs_params.svh"
module option_regs_tb;
  logic clk_in, rst_n_in, por_n_in, avs_read_in, avs_write_in;
  logic stop_instr_in, lowvolt_trip_in, ext_reset_exit_in;
  logic avs_waitrequest_out, illegal_opcode_reset_out;
  logic lowvolt_reset_out, stop_accept_out;
  logic [17:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rd_q;
  logic [12:0] stop_recovery_out;
  logic [7:0] v1, v2, w;
  option_regs_pkg::option_out_t opts_out;
  int mismatches = 0;
  int check_count = 0;
  // byte 0 always enabled: the block only uses bits 7:0
  option_regs i_option_regs (.*, .avs_byteenable_in(4'hF));
  initial begin
    clk_in = 0;
    forever #2 clk_in = ~clk_in;
  end
  // ******************************
  // shared tasks
  // ******************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reset(input logic por);
    @(posedge clk_in);
    rst_n_in <= 0;
    por_n_in <= !por;
    ext_reset_exit_in <= 0;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1;
    por_n_in <= 1;
  endtask
  task automatic bus(input logic wr, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    avs_writedata_in <= {24'($urandom()), d};
    // hold the request until waitrequest is seen low at a rising edge
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (avs_waitrequest_out === 1'b0) begin
        rd_q = avs_readdata_out;
        break;
      end
    end
    if (n == 20) begin
      mismatches++;
      close_out();
    end
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  // ******************************
  // main sequence
  // ******************************
  initial begin
    {rst_n_in, por_n_in, avs_read_in, avs_write_in} = 0;
    {stop_instr_in, lowvolt_trip_in, ext_reset_exit_in} = 0;
    avs_address_in = 0;
    avs_writedata_in = 0;
    void'($urandom(32));
    repeat (4) begin
      reset(1'b1);
      bus(0, `OPT_REG_ONE_ADDR, 0);
      chk(rd_q, 0);
      v1 = $urandom();
      v2 = $urandom();
      bus(1, `OPT_REG_ONE_ADDR, v1);
      bus(1, `OPT_REG_TWO_ADDR, v2);
      bus(1, `OPT_REG_ONE_ADDR, ~v1);
      bus(1, `OPT_REG_TWO_ADDR, ~v2);
      bus(0, `OPT_REG_ONE_ADDR, 0);
      chk(rd_q, {24'h0, v1});
      bus(0, `OPT_REG_TWO_ADDR, 0);
      chk(rd_q, {24'h0, v2 & 8'h03});
      bus(0, `OPT_CTRL_ADDR, 0);
      chk(rd_q, 0);
      bus(0, `OPT_STAT_ADDR, 0);
      chk(rd_q, 32'h0000000E);
      repeat (3) @(posedge clk_in);
      chk(opts_out.osc_run_in_stop, v2[1]);
      chk(opts_out.serial_clock_source_sel, v2[0]);
      chk(opts_out.watchdog_timeout, v1[7] ? 19'h01FF0 : 19'h3FFF0);
      chk(opts_out.lowvolt_in_stop_en & !opts_out.lowvolt_power_disable,
        v1[6] & !v1[4]);
      chk({opts_out.lowvolt_reset_disable, opts_out.lowvolt_power_disable,
        opts_out.lowvolt_voltage_mode, opts_out.watchdog_disable},
        {v1[5], v1[4], v1[3], v1[0]});
      stop_instr_in <= 1;
      lowvolt_trip_in <= 1;
      // no crystal here, so short recovery may be set freely
      ext_reset_exit_in <= v1[0];
      @(posedge clk_in);
      stop_instr_in <= 0;
      lowvolt_trip_in <= 0;
      @(negedge clk_in);
      chk(stop_accept_out, v1[1]);
      chk(illegal_opcode_reset_out, !v1[1]);
      chk(lowvolt_reset_out, !v1[5] & !v1[4]);
      chk(stop_recovery_out, (v1[2] & !v1[0]) ? 13'h0020 : 13'h1000);
      reset(1'b0);
      bus(0, `OPT_REG_ONE_ADDR, 0);
      chk(rd_q, {24'h0, v1 & 8'h08});
      w = $urandom();
      bus(1, `OPT_REG_ONE_ADDR, w);
      bus(0, `OPT_REG_ONE_ADDR, 0);
      chk(rd_q, {24'h0, (w & 8'hF7) | (v1 & 8'h08)});
    end
    close_out();
  end
endmodule
